// ---- hdl/strap_pkg.sv ----
package strap_pkg;
	localparam int MODE_W = 5;
	localparam int ADDR_W = 3;
	localparam int LED_N = 5;
	localparam int ALT_N = 5;
	localparam int MGMT_ADDR_W = 5;
	localparam int STRAP_W = 17;
	localparam int IRQ_W = 6;
	localparam int WB_AW = 8;

	// raw strap vector layout
	localparam int SP_MODE = 0;
	localparam int SP_ADDR = 5;
	localparam int SP_ALLOW = 8;
	localparam int SP_LED = 9;
	localparam int SP_STYLE = 14;
	localparam int SP_REFCLK = 15;
	localparam int SP_MAG = 16;

	// register byte addresses
	localparam logic [WB_AW-1:0] STRAP_STATUS_ADDR = 8'h00;
	localparam logic [WB_AW-1:0] OUTPUT_CONTROL_ADDR = 8'h04;
	localparam logic [WB_AW-1:0] TIMING_CONFIG_ADDR = 8'h08;
	localparam logic [WB_AW-1:0] GPIO_BUFFER_TYPE_ADDR = 8'h0C;
	localparam logic [WB_AW-1:0] IRQ_STATUS_ADDR = 8'h10;
	localparam logic [WB_AW-1:0] IRQ_MASK_ADDR = 8'h14;

	// output control fields
	localparam int OC_ALLOW = 0;
	localparam int OC_INDICATOR_POLARITY = 1;
	localparam int OC_WAKEPOL = 6;
	// timing config fields
	localparam int TC_POL_A = 0;
	localparam int TC_POL_B = 1;

	// alternate function pin indices
	localparam int ALT_WAKE = 0;
	localparam int ALT_SOF_RX = 1;
	localparam int ALT_SOF_TX = 2;
	localparam int ALT_EVT_A = 3;
	localparam int ALT_EVT_B = 4;

	// interrupt status bits
	localparam int IRQ_CAPTURE = 0;
	localparam int IRQ_WAKE = 1;
	localparam int IRQ_SOF_RX = 2;
	localparam int IRQ_SOF_TX = 3;
	localparam int IRQ_EVT_A = 4;
	localparam int IRQ_EVT_B = 5;

	localparam logic [MODE_W-1:0] MODE_PD_PLL_ON = 5'h08;
	localparam logic [MODE_W-1:0] MODE_PD_PLL_OFF = 5'h09;

	// reset values
	localparam logic [LED_N-1:0] INDICATOR_POLARITY_RESET = 5'h00;
	localparam logic [ALT_N-1:0] GPIO_BUF_RESET = 5'h00;
	localparam logic WAKE_POL_RESET = 1'b0;
	localparam logic [1:0] TIMING_POL_RESET = 2'h3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 6'h00;
endpackage

// ---- hdl/pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;

	// first stage is read only by the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_o <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/pin_driver.sv ----
`timescale 1ns/10ps
`default_nettype none
module pin_driver (
	input wire logic enable_i,
	input wire logic active_i,
	input wire logic active_high_i,
	input wire logic open_drain_i,
	output logic level_o,
	output logic oe_o
);
	logic level;

	assign level = active_i ? active_high_i : ~active_high_i;

	// open drain only ever pulls low and floats for a high level
	always_comb begin
		if (!enable_i) begin
			level_o = 1'b0;
			oe_o = 1'b0;
		end else if (open_drain_i) begin
			level_o = 1'b0;
			oe_o = ~level;
		end else begin
			level_o = level;
			oe_o = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/strap_capture_pin_config.sv ----
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module strap_capture_pin_config
	import strap_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reset_pin_n_i,
	input wire logic [MODE_W-1:0] mode_strap_i,
	input wire logic [ADDR_W-1:0] station_address_strap_i,
	input wire logic broadcast_address_allow_i,
	input wire logic indicator_style_select_i,
	input wire logic ref_clock_out_enable_i,
	input wire logic integrated_magnetics_defaults_i,
	input wire logic [LED_N-1:0] led_pin_i,
	input wire logic [LED_N-1:0] led_on_i,
	output logic [LED_N-1:0] led_pin_o,
	output logic [LED_N-1:0] led_pin_oe_o,
	input wire logic wake_event_i,
	input wire logic sof_rx_i,
	input wire logic sof_tx_i,
	input wire logic time_event_a_i,
	input wire logic time_event_b_i,
	output logic [ALT_N-1:0] gpio_pin_o,
	output logic [ALT_N-1:0] gpio_pin_oe_o,
	input wire logic [MGMT_ADDR_W-1:0] mgmt_addr_i,
	output logic mgmt_addr_match_o,
	output logic [MODE_W-1:0] operating_mode_o,
	output logic soft_power_down_o,
	output logic pll_enable_o,
	output logic ref_clock_out_pin_enable_o,
	output logic indicator_individual_o,
	output logic integrated_magnetics_defaults_o,
	output logic config_valid_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o
);
	typedef struct packed {
		logic pin_rst_n_prev;
		logic captured;
		logic [MODE_W-1:0] mode;
		logic [ADDR_W-1:0] station;
		logic allow_strap;
		logic [LED_N-1:0] led_strap;
		logic style;
		logic refclk;
		logic magnetics;
		logic allow_en;
		logic [LED_N-1:0] indicator_polarity;
		logic wake_pol;
		logic [1:0] time_pol;
		logic [ALT_N-1:0] gpio_buf;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic ack;
		logic [31:0] rdata;
		logic [LED_N-1:0] led_out;
		logic [LED_N-1:0] led_oe;
		logic [ALT_N-1:0] gpio_out;
		logic [ALT_N-1:0] gpio_oe;
		logic addr_match;
	} state_type;

	state_type state_reg;
	state_type state_next;

	logic [STRAP_W-1:0] strap_raw;
	logic [STRAP_W-1:0] strap_sync;
	logic pin_rst_n_sync;
	logic capture;
	logic [ALT_N-1:0] alt_active;
	logic [ALT_N-1:0] alt_high;
	logic [ALT_N-1:0] alt_level;
	logic [ALT_N-1:0] alt_oe;
	logic [LED_N-1:0] led_level;
	logic [LED_N-1:0] led_oe;
	logic [IRQ_W-1:0] irq_events;
	logic wb_req;
	logic wb_done;
	logic [31:0] wmask;
	logic [31:0] wdata;
	logic [31:0] rd_value;

	// led pins double as straps, read back through the same synchroniser
	assign strap_raw = {integrated_magnetics_defaults_i, ref_clock_out_enable_i, indicator_style_select_i,
		led_pin_i, broadcast_address_allow_i, station_address_strap_i, mode_strap_i};

	pin_sync #(
		.WIDTH(STRAP_W + 1)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({reset_pin_n_i, strap_raw}),
		.sync_o({pin_rst_n_sync, strap_sync})
	);

	// straps and reset ride the same two stages, so both are aligned here
	assign capture = pin_rst_n_sync & ~state_reg.pin_rst_n_prev;

	assign alt_active[ALT_WAKE] = wake_event_i;
	assign alt_active[ALT_SOF_RX] = sof_rx_i;
	assign alt_active[ALT_SOF_TX] = sof_tx_i;
	assign alt_active[ALT_EVT_A] = time_event_a_i;
	assign alt_active[ALT_EVT_B] = time_event_b_i;

	assign alt_high[ALT_WAKE] = state_reg.wake_pol;
	assign alt_high[ALT_SOF_RX] = 1'b1;
	assign alt_high[ALT_SOF_TX] = 1'b1;
	assign alt_high[ALT_EVT_A] = state_reg.time_pol[TC_POL_A];
	assign alt_high[ALT_EVT_B] = state_reg.time_pol[TC_POL_B];

	// one driver per shared pin, so buffer type and polarity stay per pin
	genvar g;
	generate
		for (g = 0; g < ALT_N; g++) begin : gen_alt
			pin_driver u_alt (
				.enable_i(state_reg.captured),
				.active_i(alt_active[g]),
				.active_high_i(alt_high[g]),
				.open_drain_i(state_reg.gpio_buf[g]),
				.level_o(alt_level[g]),
				.oe_o(alt_oe[g])
			);
		end
		for (g = 0; g < LED_N; g++) begin : gen_led
			pin_driver u_led (
				.enable_i(state_reg.captured),
				.active_i(led_on_i[g]),
				.active_high_i(state_reg.indicator_polarity[g]),
				.open_drain_i(1'b0),
				.level_o(led_level[g]),
				.oe_o(led_oe[g])
			);
		end
	endgenerate

	assign irq_events = {time_event_b_i, time_event_a_i, sof_tx_i, sof_rx_i, wake_event_i, capture};

	assign wb_req = wb_cyc_i & wb_stb_i;
	// write lands at the edge on which the master sees ack
	assign wb_done = wb_req & state_reg.ack;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
		end
		wdata = wb_dat_i & wmask;
	end

	always_comb begin
		rd_value = 32'h00000000;
		unique case (wb_adr_i)
			STRAP_STATUS_ADDR: begin
				rd_value[STRAP_W-1:0] = {state_reg.magnetics, state_reg.refclk, state_reg.style,
					state_reg.led_strap, state_reg.allow_strap, state_reg.station, state_reg.mode};
				rd_value[STRAP_W] = state_reg.captured;
			end
			OUTPUT_CONTROL_ADDR: begin
				rd_value[OC_ALLOW] = state_reg.allow_en;
				rd_value[OC_INDICATOR_POLARITY +: LED_N] = state_reg.indicator_polarity;
				rd_value[OC_WAKEPOL] = state_reg.wake_pol;
			end
			TIMING_CONFIG_ADDR: rd_value[1:0] = state_reg.time_pol;
			GPIO_BUFFER_TYPE_ADDR: rd_value[ALT_N-1:0] = state_reg.gpio_buf;
			IRQ_STATUS_ADDR: rd_value[IRQ_W-1:0] = state_reg.irq_status;
			IRQ_MASK_ADDR: rd_value[IRQ_W-1:0] = state_reg.irq_mask;
			default: rd_value = 32'h00000000;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		state_next.pin_rst_n_prev = pin_rst_n_sync;

		// holding pin reset low returns the shared pins to strap sensing
		if (!pin_rst_n_sync) begin
			state_next.captured = 1'b0;
		end
		if (capture) begin
			state_next.captured = 1'b1;
			state_next.mode = strap_sync[SP_MODE +: MODE_W];
			state_next.station = strap_sync[SP_ADDR +: ADDR_W];
			state_next.allow_strap = strap_sync[SP_ALLOW];
			state_next.allow_en = ~strap_sync[SP_ALLOW];
			state_next.led_strap = strap_sync[SP_LED +: LED_N];
			state_next.indicator_polarity = ~strap_sync[SP_LED +: LED_N];
			state_next.style = strap_sync[SP_STYLE];
			state_next.refclk = strap_sync[SP_REFCLK];
			state_next.magnetics = strap_sync[SP_MAG];
		end

		// address zero answered while the allow enable is set, or always when the station strap is zero
		state_next.addr_match = (mgmt_addr_i == {{(MGMT_ADDR_W-ADDR_W){1'b0}}, state_reg.station})
			|| (state_reg.allow_en && mgmt_addr_i == '0);

		state_next.ack = wb_req & ~state_reg.ack;
		if (wb_req && !state_reg.ack) begin
			state_next.rdata = rd_value;
		end

		if (wb_done && wb_we_i) begin
			unique case (wb_adr_i)
				OUTPUT_CONTROL_ADDR: begin
					if (wb_sel_i[0]) begin
						state_next.allow_en = wdata[OC_ALLOW];
						state_next.indicator_polarity = wdata[OC_INDICATOR_POLARITY +: LED_N];
						state_next.wake_pol = wdata[OC_WAKEPOL];
					end
				end
				TIMING_CONFIG_ADDR: begin
					if (wb_sel_i[0]) begin
						state_next.time_pol = wdata[1:0];
					end
				end
				GPIO_BUFFER_TYPE_ADDR: begin
					if (wb_sel_i[0]) begin
						state_next.gpio_buf = wdata[ALT_N-1:0];
					end
				end
				IRQ_STATUS_ADDR: state_next.irq_status = state_reg.irq_status & ~wdata[IRQ_W-1:0];
				IRQ_MASK_ADDR: begin
					if (wb_sel_i[0]) begin
						state_next.irq_mask = wdata[IRQ_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		// an event in the clearing cycle survives the clear
		state_next.irq_status = state_next.irq_status | irq_events;

		state_next.led_out = led_level;
		state_next.led_oe = led_oe;
		state_next.gpio_out = alt_level;
		state_next.gpio_oe = alt_oe;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.indicator_polarity <= INDICATOR_POLARITY_RESET;
			state_reg.wake_pol <= WAKE_POL_RESET;
			state_reg.time_pol <= TIMING_POL_RESET;
			state_reg.gpio_buf <= GPIO_BUF_RESET;
			state_reg.irq_mask <= IRQ_MASK_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign led_pin_o = state_reg.led_out;
	assign led_pin_oe_o = state_reg.led_oe;
	assign gpio_pin_o = state_reg.gpio_out;
	assign gpio_pin_oe_o = state_reg.gpio_oe;
	assign mgmt_addr_match_o = state_reg.addr_match;
	assign operating_mode_o = state_reg.mode;
	// mode decodes stay quiet while pin reset is low; the held code may be stale
	// until the next capture replaces it
	assign soft_power_down_o = state_reg.captured
		&& (state_reg.mode == MODE_PD_PLL_ON || state_reg.mode == MODE_PD_PLL_OFF);
	assign pll_enable_o = !(state_reg.captured && state_reg.mode == MODE_PD_PLL_OFF);
	assign ref_clock_out_pin_enable_o = state_reg.captured & state_reg.refclk;
	assign indicator_individual_o = state_reg.style;
	assign integrated_magnetics_defaults_o = state_reg.magnetics;
	assign config_valid_o = state_reg.captured;
	assign wb_dat_o = state_reg.rdata;
	assign wb_ack_o = state_reg.ack;
	assign irq_o = |(state_reg.irq_status & state_reg.irq_mask);
endmodule
`default_nettype wire

// ---- verif/strap_capture_pin_config_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module strap_capture_pin_config_props
	import strap_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reset_pin_n_i,
	input wire logic sof_rx_i,
	input wire logic [ALT_N-1:0] gpio_pin_o,
	input wire logic [ALT_N-1:0] gpio_pin_oe_o,
	input wire logic [MODE_W-1:0] operating_mode_o,
	input wire logic soft_power_down_o,
	input wire logic pll_enable_o,
	input wire logic config_valid_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence wb_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	ack_one_cycle_a: assert property (wb_req |=> ack_pulse)
		else $error("ack length");
	ack_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o)
		else $error("stray ack");
	capture_time_a: assert property ($rose(reset_pin_n_i) |-> ##[1:4] $rose(config_valid_o))
		else $error("capture late");
	pins_idle_a: assert property (!config_valid_o ##1 !config_valid_o |-> gpio_pin_oe_o == '0)
		else $error("early drive");
	mode_hold_a: assert property (config_valid_o ##1 config_valid_o |-> $stable(operating_mode_o))
		else $error("mode moved");
	power_down_a: assert property (soft_power_down_o == (config_valid_o && operating_mode_o[4:1] == 4'h4))
		else $error("power down");
	pll_off_a: assert property (pll_enable_o == !(config_valid_o && operating_mode_o == MODE_PD_PLL_OFF))
		else $error("pll enable");
	sof_level_a: assert property (config_valid_o |=> !config_valid_o ||
		(gpio_pin_o[1] | ~gpio_pin_oe_o[1]) == $past(sof_rx_i))
		else $error("sof level");
endmodule
bind strap_capture_pin_config strap_capture_pin_config_props u_props (.clk_i, .rst_i, .reset_pin_n_i,
	.sof_rx_i, .gpio_pin_o, .gpio_pin_oe_o, .operating_mode_o, .soft_power_down_o, .pll_enable_o,
	.config_valid_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire

// ---- verif/strap_board_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module strap_board_model (
	input wire logic clk_i,
	input wire logic pulse_i,
	input wire logic [16:0] strap_i,
	input wire logic [4:0] drv_i,
	input wire logic [4:0] oe_i,
	output logic pin_n_o,
	output logic [16:0] pins_o,
	output logic [4:0] lvl_o
);
	logic [3:0] cnt = 4'h0;
	logic armed = 1'b0;
	initial pins_o = 17'h0;
	// straps stay put through the whole low phase and long after release
	always @(posedge clk_i) begin
		if (pulse_i) begin
			cnt <= 4'h8;
			armed <= 1'b1;
			pins_o <= strap_i;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
	assign pin_n_o = armed && cnt == 4'h0;
	// resistor level shows unless the device drives
	assign lvl_o = (oe_i & drv_i) | (~oe_i & pins_o[13:9]);
endmodule
`default_nettype wire

// ---- verif/strap_capture_pin_config_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module strap_capture_pin_config_tb_top;
	import strap_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic pulse = 1'b0;
	logic [16:0] strap = 17'h0;
	logic [16:0] pins;
	logic [4:0] lvl, led_o, led_oe, gp_o, gp_oe, mode;
	logic [4:0] led_on = 5'h03;
	logic [4:0] ev = 5'h00;
	logic [4:0] mgmt = 5'h00;
	logic pin_n, match, pd, pll, refclk, indiv, magn, valid, ack, irq;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	always #2.5 clk_i = ~clk_i;
	strap_capture_pin_config u_strap_capture_pin_config (.clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(pin_n),
		.mode_strap_i(pins[4:0]), .station_address_strap_i(pins[7:5]), .broadcast_address_allow_i(pins[8]),
		.indicator_style_select_i(pins[14]), .ref_clock_out_enable_i(pins[15]),
		.integrated_magnetics_defaults_i(pins[16]), .led_pin_i(lvl), .led_on_i(led_on), .led_pin_o(led_o),
		.led_pin_oe_o(led_oe), .wake_event_i(ev[0]), .sof_rx_i(ev[1]), .sof_tx_i(ev[2]), .time_event_a_i(ev[3]),
		.time_event_b_i(ev[4]), .gpio_pin_o(gp_o), .gpio_pin_oe_o(gp_oe), .mgmt_addr_i(mgmt),
		.mgmt_addr_match_o(match), .operating_mode_o(mode), .soft_power_down_o(pd), .pll_enable_o(pll),
		.ref_clock_out_pin_enable_o(refclk), .indicator_individual_o(indiv), .integrated_magnetics_defaults_o(magn),
		.config_valid_o(valid), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
	strap_board_model u_strap_board_model (.clk_i(clk_i), .pulse_i(pulse), .strap_i(strap), .drv_i(led_o),
		.oe_i(led_oe), .pin_n_o(pin_n), .pins_o(pins), .lvl_o(lvl));
	task automatic report_and_stop();
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic mq(input logic [4:0] a, input logic e);
		mgmt <= a;
		repeat (2) @(posedge clk_i);
		chk("match", e, match);
	endtask
	task automatic t_capture(input logic [16:0] s);
		logic [31:0] q;
		strap <= s;
		pulse <= 1'b1;
		@(posedge clk_i);
		pulse <= 1'b0;
		@(posedge pin_n);
		for (int n = 0; n < 8 && valid !== 1'b1; n++)
			@(posedge clk_i);
		chk("mode", s[4:0], mode);
		chk("refclk", s[15], refclk);
		chk("style", s[14], indiv);
		chk("magnetics", s[16], magn);
		chk("power_down", s[4:1] == 4'h4, pd);
		chk("pll", s[4:0] != 5'h09, pll);
		wb(1'b0, STRAP_STATUS_ADDR, 32'h0, q);
		chk("strap_status", {15'h0001, s}, q);
		wb(1'b0, OUTPUT_CONTROL_ADDR, 32'h0, q);
		chk("output_control", {26'h0, ~s[13:9], ~s[8]}, q);
		chk("led_pins", {5'h1F, led_on ^ s[13:9]}, {led_oe, led_o});
		mq({2'b00, s[7:5]}, 1'b1);
		mq(5'h00, ~s[8] | (s[7:5] == 3'h0));
	endtask
	task automatic t_pulse(input logic [4:0] e, input logic [9:0] x);
		ev <= e;
		@(posedge clk_i);
		ev <= 5'h00;
		@(negedge clk_i);
		chk("gpio_pins", x, {gp_oe, gp_o});
		@(posedge clk_i);
	endtask
	task automatic t_events();
		logic [31:0] q;
		wb(1'b0, TIMING_CONFIG_ADDR, 32'h0, q);
		chk("timing_reset", 32'h3, q);
		wb(1'b0, 8'h1C, 32'h0, q);
		chk("unmapped", 32'h0, q);
		wb(1'b1, GPIO_BUFFER_TYPE_ADDR, 32'h5, q);
		wb(1'b1, OUTPUT_CONTROL_ADDR, 32'h40, q);
		wb(1'b1, TIMING_CONFIG_ADDR, 32'h2, q);
		wb(1'b1, IRQ_MASK_ADDR, 32'h2, q);
		wb(1'b1, IRQ_STATUS_ADDR, 32'h3F, q);
		chk("irq_idle", 1'b0, irq);
		t_pulse(5'h01, 10'h3C8);
		chk("irq_set", 1'b1, irq);
		t_pulse(5'h1E, 10'h372);
		wb(1'b0, IRQ_STATUS_ADDR, 32'h0, q);
		chk("irq_status", 32'h3E, q);
		wb(1'b1, IRQ_STATUS_ADDR, 32'h2, q);
		wb(1'b0, IRQ_STATUS_ADDR, 32'h0, q);
		chk("irq_cleared", 32'h3C, q);
		chk("irq_masked", 1'b0, irq);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_capture(17'h16AA8);
		t_capture(17'h09509);
		t_capture(17'h1FFF3);
		t_events();
		report_and_stop();
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			report_and_stop();
		end
	end
endmodule
`default_nettype wire
